// *** logic/dcp_pkg.sv ***
// Constants, register map and carrier types of the quad wiper register bank.
// Assumes a 100 MHz core clock and an SPI mode 0 master that owns SCK and chip select.
package dcp_pkg;
	// ****************************************************************
	// Structure
	// ****************************************************************
	localparam int          NUM_CH      = 4;
	localparam int          CODE_W      = 8;
	localparam int          CNT_W       = 8;
	localparam int          BITS_W      = 6;

	// ****************************************************************
	// Register map and reset values
	// ****************************************************************
	localparam logic [4:0]  CTL_ADDR    = 5'h10;
	localparam logic [7:0]  WIPER_RESET = 8'h80;
	localparam logic [7:0]  CTL_RESET   = 8'h40;
	localparam logic [7:0]  CTL_WMASK   = 8'h42;
	localparam int          CTL_SHUT_N  = 6;
	localparam int          CTL_OD      = 1;

	// ****************************************************************
	// Instruction codes and frame positions (bit counts)
	// ****************************************************************
	localparam logic [2:0]  OP_NO_OP    = 3'h0;
	localparam logic [2:0]  OP_CTL_RD   = 3'h1;
	localparam logic [2:0]  OP_CTL_WR   = 3'h3;
	localparam logic [2:0]  OP_REG_RD   = 3'h4;
	localparam logic [2:0]  OP_REG_WR   = 3'h6;
	localparam logic [5:0]  POS_INSTR   = 6'h08;
	localparam logic [5:0]  POS_ECHO    = 6'h10;
	localparam logic [5:0]  POS_DATA    = 6'h18;
	localparam logic [5:0]  POS_MAX     = 6'h3F;

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int          CLK_NS      = 10;
	localparam int          DIP_MIN_NS  = 200;
	localparam int          SETTLE_NS   = 1000;
	localparam int          MBB_NS      = 100;
	localparam logic [7:0]  DIP_CYC     = 8'((DIP_MIN_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0]  SETTLE_CYC  = 8'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [7:0]  MBB_CYC     = 8'((MBB_NS + CLK_NS - 1) / CLK_NS);

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic [2:0] op;
		logic [4:0] addr;
	} instr_t;

	typedef struct packed {
		logic [7:0] tap;
		logic [7:0] prev_tap;
		logic       overlap;
		logic       shut;
	} chan_ctrl_t;
endpackage

// *** logic/quad_wiper_register_bank.sv ***
// Register bank and SPI slave of a quad 256-tap potentiometer.
// Assumes SCK, chip select, SDI and the supply-low flag are asynchronous pins;
// all are synchronised to core_clk_i, which must run well above the SCK rate.
//
// Summary of operation
// - SDI sampled on SCK rising edges only while chip select is low.
// - SDO changes on SCK falling edges; master captures on next rising edge.
// - Control bit 1 selects SDO drive: 0 push-pull (default), 1 open drain.
// - Chip select high: deselected, SDO released, standby.
// - Chip select low enables the device into active power mode.
// - Each channel holds an 8-bit wiper code, 00h low end, FFh high end.
// - Tap moves monotonically from low to high terminal as code rises.
// - All wiper codes preset to 80h at power-up.
// - Wiper register of channel i sits at address i, i from 0 to 3.
// - Access control register sits at address 10h.
// - Control bit 6 is active-low shutdown for all channels, default 1.
// - Shutdown opens every channel and ties each wiper to its low terminal.
// - Entering shutdown keeps all wiper codes unchanged.
// - Leaving shutdown restores retained taps after a short settling time.
// - Supply dip during shutdown resets all wiper codes to mid-scale.
// - Tap changes are make-before-break: new tap connects before old opens.
// - Bytes move MSB first in SPI mode 0.
// - Frame starts with instruction byte: 3-bit opcode, 5-bit address.
// - Writes take effect only at the chip select rising edge.
// - Read is four bytes; bytes three and four return instruction then data.
`timescale 1ns/1ns
module quad_wiper_register_bank (
	input  wire logic                                  core_clk_i,
	input  wire logic                                  nrst_i,
	input  wire logic                                  sck_i,
	input  wire logic                                  cs_n_i,
	input  wire logic                                  sdi_i,
	input  wire logic                                  supply_low_i,
	output logic                                       sdo_o,
	output logic                                       sdo_oe_o,
	output logic                                       standby_o,
	output dcp_pkg::chan_ctrl_t [dcp_pkg::NUM_CH-1:0]  chan_o
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [1:0] sck_s_q;
	logic [1:0] cs_s_q;
	logic [1:0] sdi_s_q;
	logic [1:0] low_s_q;
	logic       sck_prev_q;
	logic       cs_prev_q;

	// Chip select sync resets low, so a select held low since power-up never
	// shows a falling edge and is not taken as a frame
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			sck_s_q    <= 2'h0;
			cs_s_q     <= 2'h0;
			sdi_s_q    <= 2'h0;
			low_s_q    <= 2'h0;
			sck_prev_q <= 1'b0;
			cs_prev_q  <= 1'b0;
		end else begin
			sck_s_q    <= {sck_s_q[0], sck_i};
			cs_s_q     <= {cs_s_q[0], cs_n_i};
			sdi_s_q    <= {sdi_s_q[0], sdi_i};
			low_s_q    <= {low_s_q[0], supply_low_i};
			sck_prev_q <= sck_s_q[1];
			cs_prev_q  <= cs_s_q[1];
		end
	end

	logic sck_rise;
	logic sck_fall;
	logic cs_fall;
	logic cs_rise;

	// Edge strobes, each one core cycle wide
	assign sck_rise = sck_s_q[1] & ~sck_prev_q;
	assign sck_fall = ~sck_s_q[1] & sck_prev_q;
	assign cs_fall  = ~cs_s_q[1] & cs_prev_q;
	assign cs_rise  = cs_s_q[1] & ~cs_prev_q;

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	function automatic logic is_rd(input dcp_pkg::instr_t ins);
		return (ins.op == dcp_pkg::OP_CTL_RD) || (ins.op == dcp_pkg::OP_REG_RD);
	endfunction

	function automatic logic is_wr(input dcp_pkg::instr_t ins);
		return (ins.op == dcp_pkg::OP_CTL_WR) || (ins.op == dcp_pkg::OP_REG_WR);
	endfunction

	// Control-only opcodes ignore the address field
	function automatic logic [4:0] eff_addr(input dcp_pkg::instr_t ins);
		if ((ins.op == dcp_pkg::OP_CTL_RD) || (ins.op == dcp_pkg::OP_CTL_WR))
			return dcp_pkg::CTL_ADDR;
		return ins.addr;
	endfunction

	// ****************************************************************
	// Register file state
	// ****************************************************************
	logic [dcp_pkg::NUM_CH-1:0][7:0] wiper_q;
	logic [dcp_pkg::NUM_CH-1:0][7:0] wiper_d;
	logic [7:0]                      ctl_q;
	logic [7:0]                      ctl_d;

	// Read mux; unmapped addresses return zero
	function automatic logic [7:0] rd_value(input logic [4:0] a,
		input logic [dcp_pkg::NUM_CH-1:0][7:0] w, input logic [7:0] c);
		if (a == dcp_pkg::CTL_ADDR)
			return c & dcp_pkg::CTL_WMASK;
		if (int'(a) < dcp_pkg::NUM_CH)
			return w[a[1:0]];
		return 8'h00;
	endfunction

	// ****************************************************************
	// Serial engine
	// ****************************************************************
	logic            frame_q;
	logic            frame_d;
	logic [5:0]      bits_q;
	logic [5:0]      bits_d;
	logic [7:0]      rx_q;
	logic [7:0]      rx_d;
	dcp_pkg::instr_t instr_q;
	dcp_pkg::instr_t instr_d;
	logic [7:0]      data_q;
	logic [7:0]      data_d;
	logic            have_q;
	logic            have_d;
	logic [7:0]      tx_q;
	logic [7:0]      tx_d;
	logic            sdo_d;
	logic            sdo_oe_d;
	logic            wr_go;

	// Frame tracking, shifting in on rising and out on falling SCK edges
	always_comb begin
		frame_d  = frame_q;
		bits_d   = bits_q;
		rx_d     = rx_q;
		instr_d  = instr_q;
		data_d   = data_q;
		have_d   = have_q;
		tx_d     = tx_q;
		wr_go    = 1'b0;
		if (cs_fall) begin
			frame_d = 1'b1;
			bits_d  = 6'h00;
			have_d  = 1'b0;
			tx_d    = 8'h00;
		end else if (cs_rise || cs_s_q[1]) begin
			// Partial trailing bytes are simply dropped
			wr_go   = cs_rise & frame_q & have_q & is_wr(instr_q);
			frame_d = 1'b0;
			tx_d    = 8'h00;
		end else if (frame_q && sck_rise) begin
			rx_d = {rx_q[6:0], sdi_s_q[1]};
			if (bits_q != dcp_pkg::POS_MAX)
				bits_d = bits_q + 6'h01;
			if (bits_d[2:0] == 3'h0) begin
				if (bits_d == dcp_pkg::POS_INSTR) begin
					instr_d = dcp_pkg::instr_t'(rx_d);
				end else begin
					data_d = rx_d;  // Last complete data byte wins, up to the sixth (bit count saturates at 63)
					have_d = 1'b1;
				end
			end
		end else if (frame_q && sck_fall) begin
			// Loading on the falling edge gives the master a full half period
			if (is_rd(instr_q) && bits_q == dcp_pkg::POS_ECHO)
				tx_d = instr_q;
			else if (is_rd(instr_q) && bits_q == dcp_pkg::POS_DATA)
				tx_d = rd_value(eff_addr(instr_q), wiper_q, ctl_q);
			else
				tx_d = {tx_q[6:0], 1'b0};
		end
		// Open drain only pulls low; push-pull drives both levels
		if (ctl_q[dcp_pkg::CTL_OD]) begin
			sdo_d    = 1'b0;
			sdo_oe_d = frame_d & ~tx_d[7];
		end else begin
			sdo_d    = tx_d[7];
			sdo_oe_d = frame_d;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			frame_q   <= 1'b0;
			bits_q    <= 6'h00;
			rx_q      <= 8'h00;
			instr_q   <= '0;
			data_q    <= 8'h00;
			have_q    <= 1'b0;
			tx_q      <= 8'h00;
			sdo_o     <= 1'b0;
			sdo_oe_o  <= 1'b0;
			standby_o <= 1'b1;
		end else begin
			frame_q   <= frame_d;
			bits_q    <= bits_d;
			rx_q      <= rx_d;
			instr_q   <= instr_d;
			data_q    <= data_d;
			have_q    <= have_d;
			tx_q      <= tx_d;
			sdo_o     <= sdo_d;
			sdo_oe_o  <= sdo_oe_d;
			standby_o <= ~frame_d;
		end
	end

	// ****************************************************************
	// Register updates and supply dip guard
	// ****************************************************************
	logic [7:0] dip_q;
	logic [7:0] dip_d;
	logic       shut_req;
	logic       dip_hit;
	logic [4:0] wr_addr;

	assign shut_req = ~ctl_q[dcp_pkg::CTL_SHUT_N];
	assign wr_addr  = eff_addr(instr_q);

	// Dip must persist for the minimum time while shut down; the power event
	// wins over a write landing in the same cycle
	always_comb begin
		wiper_d = wiper_q;
		ctl_d   = ctl_q;
		dip_d   = 8'h00;
		dip_hit = 1'b0;
		if (shut_req && low_s_q[1]) begin
			dip_d   = (dip_q == dcp_pkg::DIP_CYC) ? dip_q : dip_q + 8'h01;
			dip_hit = (dip_d == dcp_pkg::DIP_CYC);
		end
		if (wr_go) begin
			if (wr_addr == dcp_pkg::CTL_ADDR)
				ctl_d = data_q & dcp_pkg::CTL_WMASK;
			else if (int'(wr_addr) < dcp_pkg::NUM_CH)
				wiper_d[wr_addr[1:0]] = data_q;
		end
		if (dip_hit) begin
			for (int i = 0; i < dcp_pkg::NUM_CH; i++)
				wiper_d[i] = dcp_pkg::WIPER_RESET;
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			wiper_q <= {dcp_pkg::NUM_CH{dcp_pkg::WIPER_RESET}};
			ctl_q   <= dcp_pkg::CTL_RESET;
			dip_q   <= 8'h00;
		end else begin
			wiper_q <= wiper_d;
			ctl_q   <= ctl_d;
			dip_q   <= dip_d;
		end
	end

	// ****************************************************************
	// Tap switch control
	// ****************************************************************
	logic [7:0]                      settle_q;
	logic [7:0]                      settle_d;
	logic [dcp_pkg::NUM_CH-1:0][7:0] tap_q;
	logic [dcp_pkg::NUM_CH-1:0][7:0] tap_d;
	logic [dcp_pkg::NUM_CH-1:0][7:0] prev_q;
	logic [dcp_pkg::NUM_CH-1:0][7:0] prev_d;
	logic [dcp_pkg::NUM_CH-1:0][7:0] mbb_q;
	logic [dcp_pkg::NUM_CH-1:0][7:0] mbb_d;

	// Tap index equals the code, so selection is monotonic by construction;
	// the old tap stays closed for a while after the new one makes
	always_comb begin
		settle_d = (settle_q != 8'h00) ? settle_q - 8'h01 : 8'h00;
		if (shut_req)
			settle_d = dcp_pkg::SETTLE_CYC;
		for (int i = 0; i < dcp_pkg::NUM_CH; i++) begin
			tap_d[i]  = tap_q[i];
			prev_d[i] = prev_q[i];
			mbb_d[i]  = (mbb_q[i] != 8'h00) ? mbb_q[i] - 8'h01 : 8'h00;
			if (wiper_q[i] != tap_q[i]) begin
				tap_d[i]  = wiper_q[i];
				prev_d[i] = tap_q[i];
				mbb_d[i]  = dcp_pkg::MBB_CYC;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			settle_q <= 8'h00;
			tap_q    <= {dcp_pkg::NUM_CH{dcp_pkg::WIPER_RESET}};
			prev_q   <= {dcp_pkg::NUM_CH{dcp_pkg::WIPER_RESET}};
			mbb_q    <= '0;
		end else begin
			settle_q <= settle_d;
			tap_q    <= tap_d;
			prev_q   <= prev_d;
			mbb_q    <= mbb_d;
		end
	end

	// Taps straight from flops; overlap and shut decoded from their counters
	always_comb begin
		for (int i = 0; i < dcp_pkg::NUM_CH; i++) begin
			chan_o[i].tap      = tap_q[i];
			chan_o[i].prev_tap = prev_q[i];
			chan_o[i].overlap  = (mbb_q[i] != 8'h00);
			chan_o[i].shut     = (settle_q != 8'h00);
		end
	end

endmodule

// *** verif/quad_wiper_register_bank_assertions.sv ***
// Port checker of the quad wiper register bank, bound to its top module.
// Assumes one core clock domain; SPI pins are watched raw, before sync.
`timescale 1ns/1ns
module quad_wiper_register_bank_assertions (
	input wire logic                                      core_clk_i,
	input wire logic                                      nrst_i,
	input wire logic                                      sck_i,
	input wire logic                                      cs_n_i,
	input wire logic                                      sdi_i,
	input wire logic                                      supply_low_i,
	input wire logic                                      sdo_o,
	input wire logic                                      sdo_oe_o,
	input wire logic                                      standby_o,
	input wire dcp_pkg::chan_ctrl_t [dcp_pkg::NUM_CH-1:0] chan_o
);
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!nrst_i);
	// ******
	// Helpers
	// ******
	logic [4:0] dip_q;
	logic [4:0] dip_d;
	// Dip length while shut; saturates so a long dip never wraps
	always_comb begin
		dip_d = 5'h00;
		if (supply_low_i && chan_o[0].shut)
			dip_d = (dip_q == 5'h1F) ? dip_q : dip_q + 5'h01;
	end
	logic [4:0] ovl_q;
	logic [4:0] ovl_d;
	// Overlap run length on channel 1; a long run is counted, not unrolled
	always_comb begin
		ovl_d = 5'h00;
		if (chan_o[1].overlap)
			ovl_d = (ovl_q == 5'h1F) ? ovl_q : ovl_q + 5'h01;
	end
	always_ff @(posedge core_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			dip_q <= 5'h00;
			ovl_q <= 5'h00;
		end else begin
			dip_q <= dip_d;
			ovl_q <= ovl_d;
		end
	end
	// Six cycles cover the two-flop sync, edge detect and output flop
	sequence idle_s;
		cs_n_i [*6];
	endsequence
	sequence busy_s;
		!cs_n_i [*6];
	endsequence
	// Old tap released after exactly the make-before-break count
	sequence hold_s;
		!chan_o[1].overlap && ovl_q == 5'(dcp_pkg::MBB_CYC);
	endsequence
	// ******
	// Assertions
	// ******
	standby_idle_a: assert property (idle_s |-> standby_o && !sdo_oe_o)
		else $error("Idle link but no standby or SDO still driven");
	active_mode_a: assert property (busy_s |-> !standby_o)
		else $error("Selected device still in standby");
	sdo_edge_a: assert property ($changed(sdo_o) && !cs_n_i |-> !sck_i)
		else $error("SDO moved while SCK high");
	write_at_rise_a: assert property (
		$changed(chan_o[0].tap) || $changed(chan_o[3].tap) |-> $past(cs_n_i, 3))
		else $error("Wiper changed inside a frame");
	reset_preset_a: assert property (
		$rose(nrst_i) |-> chan_o[2].tap == dcp_pkg::WIPER_RESET && !chan_o[2].shut)
		else $error("Wiper not at mid-scale after reset");
	mbb_start_a: assert property ($changed(chan_o[1].tap) |->
		chan_o[1].overlap && chan_o[1].prev_tap == $past(chan_o[1].tap))
		else $error("New tap without overlap on old tap");
	mbb_hold_a: assert property ($fell(chan_o[1].overlap) |-> hold_s)
		else $error("Overlap length wrong");
	shut_all_a: assert property (chan_o[0].shut |->
		chan_o[1].shut && chan_o[2].shut && chan_o[3].shut)
		else $error("Shutdown not on all channels");
	keep_code_a: assert property ($rose(chan_o[0].shut) |-> $stable(chan_o[0].tap))
		else $error("Wiper code lost on shutdown");
	dip_reset_a: assert property (dip_q == 5'h1E |->
		chan_o[0].tap == dcp_pkg::WIPER_RESET && chan_o[3].tap == dcp_pkg::WIPER_RESET)
		else $error("Supply dip in shutdown left wipers");
endmodule
bind quad_wiper_register_bank quad_wiper_register_bank_assertions chk_u (
	.core_clk_i(core_clk_i), .nrst_i(nrst_i), .sck_i(sck_i), .cs_n_i(cs_n_i),
	.sdi_i(sdi_i), .supply_low_i(supply_low_i), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
	.standby_o(standby_o), .chan_o(chan_o)
);

// *** verif/spi_master_model.sv ***
// SPI mode 0 master standing in for the host on the far side of the link.
// Assumes the bench core clock; SCK period is eight core periods, 80 ns.
`timescale 1ns/1ns
module spi_master_model (
	input  wire logic clk_i,
	input  wire logic sdo_i,
	output logic      sck_o,
	output logic      cs_n_o,
	output logic      sdi_o
);
	// Idle lines: clock parked low, device deselected
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o = 1'b0;
	end
	// One whole frame of nb bytes; tx left aligned, rx right aligned
	task automatic frame(input int nb, input logic [31:0] tx, output logic [31:0] rx);
		rx = 32'h0000_0000;
		@(negedge clk_i);
		cs_n_o = 1'b0;
		repeat (8) @(negedge clk_i);
		for (int b = 0; b < 8 * nb; b++) begin
			sdi_o = tx[31 - b];
			repeat (4) @(negedge clk_i);
			sck_o = 1'b1;
			rx = {rx[30:0], sdo_i};
			repeat (4) @(negedge clk_i);
			sck_o = 1'b0;
		end
		repeat (8) @(negedge clk_i);
		cs_n_o = 1'b1;
		sdi_o = ~sdi_o; // Released data line must not look held
		repeat (16) @(negedge clk_i);
	endtask
endmodule

// *** verif/quad_wiper_register_bank_bench.sv ***
// Self-checking bench of the quad wiper register bank.
// Assumes the SPI master model drives the link; SDO has a pull-up.
`timescale 1ns/1ns
module quad_wiper_register_bank_bench;
	logic                                      core_clk_i, nrst_i, supply_low_i;
	logic                                      sck, cs_n, sdi, sdo, sdo_oe, stby, sdo_w;
	dcp_pkg::chan_ctrl_t [dcp_pkg::NUM_CH-1:0] chan;
	logic [31:0]                               rx;
	int                                        error_cnt, samples_checked, cyc, seed, ctl, i;
	int                                        wip [4];
	// Pull-up holds the released line high
	assign sdo_w = sdo_oe ? sdo : 1'b1;
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end
	quad_wiper_register_bank dut_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .sck_i(sck),
		.cs_n_i(cs_n), .sdi_i(sdi), .supply_low_i(supply_low_i), .sdo_o(sdo),
		.sdo_oe_o(sdo_oe), .standby_o(stby), .chan_o(chan));
	spi_master_model master_u (.clk_i(core_clk_i), .sdo_i(sdo_w), .sck_o(sck), .cs_n_o(cs_n),
		.sdi_o(sdi));
	task automatic report_and_stop();
		$display("Checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Taps and shut flags of all channels against the model
	task automatic taps();
		for (int k = 0; k < 4; k++) begin
			chk("tap", chan[k].tap, 8'(wip[k]));
			chk("shut", {7'h00, chan[k].shut}, {7'h00, ~ctl[6]});
		end
	endtask
	task automatic wr(input logic [2:0] op, input logic [4:0] a, input logic [7:0] d);
		master_u.frame(2, {op, a, d, 16'h0000}, rx);
		if (op == dcp_pkg::OP_CTL_WR || (op == dcp_pkg::OP_REG_WR && a == dcp_pkg::CTL_ADDR))
			ctl = d & 8'h42;
		else if (op == dcp_pkg::OP_REG_WR && a < 4)
			wip[a] = d;
		chk("standby", {7'h00, stby}, 8'h01);
		chk("release", {7'h00, sdo_oe}, 8'h00);
	endtask
	task automatic rd(input logic [2:0] op, input logic [4:0] a);
		int e;
		master_u.frame(4, {op, a, 8'h00, dcp_pkg::OP_NO_OP, 5'h00, 8'h00}, rx);
		e = (op == dcp_pkg::OP_CTL_RD || a == dcp_pkg::CTL_ADDR) ? ctl : (a < 4) ? wip[a] : 0;
		chk("echo", rx[15:8], {op, a});
		chk("data", rx[7:0], 8'(e));
	endtask
	// Supply dip of 32 cycles; resets the model only while shut
	task automatic dip();
		supply_low_i = 1'b1;
		repeat (32) @(negedge core_clk_i);
		supply_low_i = 1'b0;
		repeat (8) @(negedge core_clk_i);
		if (ctl[6] == 0)
			for (int k = 0; k < 4; k++) wip[k] = 8'h80;
	endtask
	// Hang guard, well above the roughly 4100 cycles of the sequence
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			report_and_stop();
		end
	end
	initial begin
		seed = 5050;
		error_cnt = 0;
		samples_checked = 0;
		cyc = 0;
		nrst_i = 1'b0;
		supply_low_i = 1'b0;
		ctl = 8'h40;
		for (i = 0; i < 4; i++) wip[i] = 8'h80;
		repeat (12) @(negedge core_clk_i);
		nrst_i = 1'b1;
		repeat (8) @(negedge core_clk_i);
		taps();
		rd(dcp_pkg::OP_CTL_RD, 5'h00);
		for (i = 0; i < 4; i++) wr(dcp_pkg::OP_REG_WR, 5'(i), 8'($random(seed)));
		for (i = 0; i < 4; i++) rd(dcp_pkg::OP_REG_RD, 5'(i));
		taps();
		wr(3'h7, 5'h00, 8'h11);
		wr(dcp_pkg::OP_REG_WR, 5'h05, 8'h5A);
		rd(dcp_pkg::OP_REG_RD, 5'h05);
		dip();
		taps();
		// Open drain readback through the pull-up
		wr(dcp_pkg::OP_CTL_WR, 5'h00, 8'hFF);
		rd(dcp_pkg::OP_REG_RD, 5'h01);
		rd(dcp_pkg::OP_REG_RD, dcp_pkg::CTL_ADDR);
		wr(dcp_pkg::OP_REG_WR, dcp_pkg::CTL_ADDR, 8'h00);
		taps();
		dip();
		taps();
		wr(dcp_pkg::OP_REG_WR, 5'h02, 8'h3C);
		wr(dcp_pkg::OP_REG_WR, dcp_pkg::CTL_ADDR, 8'h40);
		chk("settle", {7'h00, chan[2].shut}, 8'h01);
		repeat (120) @(negedge core_clk_i);
		taps();
		report_and_stop();
	end
endmodule
